// file: include/trace_qual_pkg.sv
// Package: constants, types and register map of the trace qualifier.
// Assumes one bus-cycle clock and a plain address/strobe register port.
package trace_qual_pkg;
    localparam int ADDR_W   = 24;
    localparam int DATA_W   = 16;
    localparam int AUX_W    = 8;
    localparam int N_EV     = 16;
    localparam int EVSEL_W  = 4;
    localparam int MEM_AW   = 22;    // Four mega records
    localparam int FIFO_D   = 16;
    localparam int CTRL_W   = 21;

    // Monitored bus cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              data_hit;  // Instruction touched the data
    } bus_cycle_t;

    // Stored trace record
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [AUX_W-1:0]  aux;
    } record_t;

    typedef enum logic [2:0] {
        fill_until_stop_mode     = 3'h0,
        fill_until_full_mode     = 3'h1,
        fill_around_trigger_mode = 3'h2,
        repeat_stop_mode         = 3'h3,
        repeat_full_mode         = 3'h4
    } trace_mode_t;

    typedef enum logic [2:0] {
        qual_none       = 3'h0,
        ext_between     = 3'h1,
        ext_during      = 3'h2,
        ext_subroutine  = 3'h3,
        ext_data_access = 3'h4,
        elim_between    = 3'h5,
        elim_during     = 3'h6,
        elim_subroutine = 3'h7
    } qual_t;

    typedef enum logic [1:0] {
        aux_event_number = 2'h0,
        aux_os_task      = 2'h1,
        aux_ext_trigger  = 2'h2
    } aux_sel_t;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] RANGE_LO_OFS = 8'h04;
    localparam logic [7:0] RANGE_HI_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS   = 8'h0c;
    localparam logic [7:0] WR_PTR_OFS   = 8'h10;
    localparam logic [7:0] MEM_ADR_OFS  = 8'h14;
    localparam logic [7:0] MEM_LO_OFS   = 8'h18;
    localparam logic [7:0] MEM_HI_OFS   = 8'h1c;

    // Control field positions
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_MODE  = 1;
    localparam int CTRL_QUAL  = 4;
    localparam int CTRL_AUX   = 7;
    localparam int CTRL_START = 9;
    localparam int CTRL_END   = 13;
    localparam int CTRL_SEL   = 17;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST  = 21'h000000;
    localparam logic [ADDR_W-1:0] RANGE_RST = 24'h000000;
endpackage : trace_qual_pkg

// file: verilog/trace_capture_qualifier.sv
// Trace capture qualifier: record FIFO and qualifier/trace store top.
// Assumes bus cycles and event hits arrive on core_clk_in.
//
// Function
// - Qualification only in three non-repeating modes
// - Extract from start event, end cycle excluded
// - Eliminate from start event through end cycle
// - Extract-during stores cycles with event true
// - Eliminate-during drops cycles with event true
// - Subroutine variants need event inside address range
// - Data-access extraction stores matching instructions only
// - Record carries event number, task, or trigger
// - Reading records never alters trace memory
// - Fill-until-stop is circular, overwriting oldest records
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module trace_rec_fifo #(
    parameter int W     = 48,
    parameter int DEPTH = 16
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         ce_in,
    // Fill side
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    // Drain side
    output logic              out_valid_out,
    output logic [W-1:0]      out_data_out,
    input  wire logic         out_ready_in,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);

    // Elaboration check: depth must be a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : bad_depth_g
        $error("fifo depth must be a power of two");
    end

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    // Pointer and count update
    always_comb begin
        in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
        out_valid_out = (cnt_r != '0);
        out_data_out  = mem_r[rd_r];
        level_out     = cnt_r;
        push    = in_valid_in && in_ready_out;
        pop     = out_valid_out && out_ready_in;
        wr_nxt  = push ? wr_r + AW'(1) : wr_r;
        rd_nxt  = pop ? rd_r + AW'(1) : rd_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_r  <= '0;
            wr_r  <= '0;
            cnt_r <= '0;
        end else if (ce_in) begin
            rd_r  <= rd_nxt;
            wr_r  <= wr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage array
    always_ff @(posedge clk_in) begin
        if (ce_in && push)
            mem_r[wr_r] <= in_data_in;
    end
endmodule : trace_rec_fifo

module trace_capture_qualifier #(
    parameter int N_EV   = trace_qual_pkg::N_EV,
    parameter int MEM_AW = trace_qual_pkg::MEM_AW
) (
    // Clock, reset, enable
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        ce_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [31:0]      reg_rdata_out,
    // Monitored bus and event detectors
    input  wire logic        bus_valid_in,
    input  wire trace_qual_pkg::bus_cycle_t bus_cycle_in,
    input  wire logic [N_EV-1:0] event_hit_in,
    input  wire logic [trace_qual_pkg::AUX_W-1:0] os_task_identifier_in,
    input  wire logic        ext_trigger_in,
    output logic             bus_ready_out,
    // Status
    output logic             acquiring_out,
    output logic             mem_full_out
);
    localparam int RW = $bits(trace_qual_pkg::record_t);
    localparam int FD = trace_qual_pkg::FIFO_D;

    // Elaboration check: event count and store size
    if (N_EV < 1 || N_EV > 16 || MEM_AW < 2 || MEM_AW > 24) begin : bad_cfg_g
        $error("unsupported event count or memory size");
    end

    // Reset release and trigger pin synchronisers
    logic [1:0] rst_s_r, ext_s_r;
    logic       rst_b_r;
    assign rst_b_r = rst_s_r[1];
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            rst_s_r <= 2'h0;
        else
            rst_s_r <= {rst_s_r[0], 1'b1};
    end
    always_ff @(posedge core_clk_in or negedge rst_b_r) begin
        if (!rst_b_r)
            ext_s_r <= 2'h0;
        else if (ce_in)
            ext_s_r <= {ext_s_r[0], ext_trigger_in};
    end

    logic [trace_qual_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [trace_qual_pkg::ADDR_W-1:0] lo_r, lo_nxt, hi_r, hi_nxt;
    logic [MEM_AW-1:0] wr_ptr_r, wr_ptr_nxt, madr_r, madr_nxt;
    logic        wrap_r, wrap_nxt, win_r, win_nxt, rdy_r, rdy_nxt;
    logic [31:0] rdata_nxt;
    logic        run_r, acc, store, mem_rd, mem_we, stop_full;
    logic        start_h, end_h, sel_h, in_rng, ev_nr_hit;
    logic [15:0] ev_pad;
    logic [3:0]  ev_nr;
    logic [trace_qual_pkg::AUX_W-1:0] aux_v;
    trace_qual_pkg::trace_mode_t mode;
    trace_qual_pkg::qual_t       qual;
    trace_qual_pkg::aux_sel_t    aux_sel;
    trace_qual_pkg::record_t     rec, f_out, mem_r [2**MEM_AW];
    logic        f_in_rdy, f_out_val;
    logic [$clog2(FD):0] f_lvl;

    // Field decode
    always_comb begin
        run_r   = ctrl_r[trace_qual_pkg::CTRL_RUN];
        mode    = trace_qual_pkg::trace_mode_t'(
                      ctrl_r[trace_qual_pkg::CTRL_MODE +: 3]);
        qual    = trace_qual_pkg::qual_t'(
                      ctrl_r[trace_qual_pkg::CTRL_QUAL +: 3]);
        aux_sel = trace_qual_pkg::aux_sel_t'(
                      ctrl_r[trace_qual_pkg::CTRL_AUX +: 2]);
        ev_pad  = 16'(event_hit_in);
        start_h = ev_pad[ctrl_r[trace_qual_pkg::CTRL_START +: 4]];
        end_h   = ev_pad[ctrl_r[trace_qual_pkg::CTRL_END +: 4]];
        sel_h   = ev_pad[ctrl_r[trace_qual_pkg::CTRL_SEL +: 4]];
        in_rng  = (bus_cycle_in.addr >= lo_r)
                  && (bus_cycle_in.addr <= hi_r);
    end

    // Lowest matching event number
    always_comb begin
        ev_nr     = 4'h0;
        ev_nr_hit = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (ev_pad[i]) begin
                ev_nr     = 4'(i);
                ev_nr_hit = 1'b1;
            end
        end
    end

    // Qualification decision for one bus cycle
    always_comb begin
        acc     = bus_valid_in && rdy_r && run_r && ce_in;
        store   = 1'b1;
        win_nxt = win_r;
        if (mode == trace_qual_pkg::repeat_stop_mode
            || mode == trace_qual_pkg::repeat_full_mode) begin
            store = 1'b1;
        end else begin
            case (qual)
                trace_qual_pkg::ext_between: begin
                    store = (start_h || win_r) && !end_h;
                end
                trace_qual_pkg::elim_between: begin
                    store = !(start_h || win_r);
                end
                trace_qual_pkg::ext_during:
                    store = sel_h;
                trace_qual_pkg::elim_during:
                    store = !sel_h;
                trace_qual_pkg::ext_subroutine:
                    store = sel_h && in_rng;
                trace_qual_pkg::elim_subroutine:
                    store = !(sel_h && in_rng);
                trace_qual_pkg::ext_data_access:
                    store = bus_cycle_in.data_hit;
                default:
                    store = 1'b1;
            endcase
        end
        // Window spans start cycle through end cycle; closed while idle
        if (!run_r)
            win_nxt = 1'b0;
        else if (acc)
            win_nxt = (start_h || win_r) && !end_h;
    end

    // Auxiliary field selection
    always_comb begin
        case (aux_sel)
            trace_qual_pkg::aux_os_task:
                aux_v = os_task_identifier_in;
            trace_qual_pkg::aux_ext_trigger:
                aux_v = trace_qual_pkg::AUX_W'(ext_s_r[1]);
            default:
                aux_v = {ev_nr_hit, 3'h0, ev_nr};
        endcase
        rec.addr = bus_cycle_in.addr;
        rec.data = bus_cycle_in.data;
        rec.aux  = aux_v;
    end

    trace_rec_fifo #(.W(RW), .DEPTH(FD)) rec_fifo (
        .clk_in        (core_clk_in),
        .rst_b_in      (rst_b_r),
        .ce_in         (ce_in),
        .in_valid_in   (acc && store),
        .in_data_in    (rec),
        .in_ready_out  (f_in_rdy),
        .out_valid_out (f_out_val),
        .out_data_out  (f_out),
        .out_ready_in  (!mem_rd),
        .level_out     (f_lvl)
    );

    // Register file, trace store pointer and read data
    always_comb begin
        mem_rd     = reg_rd_in && (reg_addr_in == trace_qual_pkg::MEM_LO_OFS
                     || reg_addr_in == trace_qual_pkg::MEM_HI_OFS);
        stop_full  = (mode == trace_qual_pkg::fill_until_full_mode
                     || mode == trace_qual_pkg::repeat_full_mode) && wrap_r;
        mem_we     = f_out_val && !mem_rd && !stop_full;
        ctrl_nxt   = ctrl_r;
        lo_nxt     = lo_r;
        hi_nxt     = hi_r;
        madr_nxt   = madr_r;
        wr_ptr_nxt = wr_ptr_r;
        wrap_nxt   = wrap_r;
        rdy_nxt    = f_in_rdy && (f_lvl < ($clog2(FD)+1)'(FD - 1));
        if (mem_we) begin
            wr_ptr_nxt = wr_ptr_r + MEM_AW'(1);
            if (wr_ptr_r == '1)
                wrap_nxt = 1'b1;
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                trace_qual_pkg::CTRL_OFS: begin
                    if (run_r) begin
                        ctrl_nxt[trace_qual_pkg::CTRL_RUN] =
                            reg_wdata_in[trace_qual_pkg::CTRL_RUN];
                    end else begin
                        ctrl_nxt = reg_wdata_in[trace_qual_pkg::CTRL_W-1:0];
                        if (reg_wdata_in[trace_qual_pkg::CTRL_RUN]) begin
                            wr_ptr_nxt = '0;
                            wrap_nxt   = mem_we && wr_ptr_r == '1; // Set wins
                        end
                    end
                end
                trace_qual_pkg::RANGE_LO_OFS:
                    if (!run_r) lo_nxt = reg_wdata_in[23:0];
                trace_qual_pkg::RANGE_HI_OFS:
                    if (!run_r) hi_nxt = reg_wdata_in[23:0];
                trace_qual_pkg::MEM_ADR_OFS:
                    madr_nxt = reg_wdata_in[MEM_AW-1:0];
                default: ;
            endcase
        end
        rdata_nxt = 32'h0;
        if (reg_rd_in) begin
            case (reg_addr_in)
                trace_qual_pkg::CTRL_OFS:
                    rdata_nxt = 32'(ctrl_r);
                trace_qual_pkg::RANGE_LO_OFS: rdata_nxt = 32'(lo_r);
                trace_qual_pkg::RANGE_HI_OFS: rdata_nxt = 32'(hi_r);
                trace_qual_pkg::STATUS_OFS:
                    rdata_nxt = {28'h0, stop_full, win_r, wrap_r, run_r};
                trace_qual_pkg::WR_PTR_OFS: rdata_nxt = 32'(wr_ptr_r);
                trace_qual_pkg::MEM_ADR_OFS: rdata_nxt = 32'(madr_r);
                trace_qual_pkg::MEM_LO_OFS:
                    rdata_nxt = 32'(mem_r[madr_r].addr);
                trace_qual_pkg::MEM_HI_OFS:
                    rdata_nxt = {8'h0, mem_r[madr_r].aux,
                                 mem_r[madr_r].data};
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_r) begin
        if (!rst_b_r) begin
            ctrl_r        <= trace_qual_pkg::CTRL_RST;
            lo_r          <= trace_qual_pkg::RANGE_RST;
            hi_r          <= trace_qual_pkg::RANGE_RST;
            madr_r        <= '0;
            wr_ptr_r      <= '0;
            wrap_r        <= 1'b0;
            win_r         <= 1'b0;
            rdy_r         <= 1'b0;
            reg_rdata_out <= 32'h0;
            bus_ready_out <= 1'b0;
            acquiring_out <= 1'b0;
            mem_full_out  <= 1'b0;
        end else if (ce_in) begin
            ctrl_r        <= ctrl_nxt;
            lo_r          <= lo_nxt;
            hi_r          <= hi_nxt;
            madr_r        <= madr_nxt;
            wr_ptr_r      <= wr_ptr_nxt;
            wrap_r        <= wrap_nxt;
            win_r         <= win_nxt;
            rdy_r         <= rdy_nxt;
            reg_rdata_out <= rdata_nxt;
            bus_ready_out <= rdy_nxt;
            acquiring_out <= ctrl_nxt[trace_qual_pkg::CTRL_RUN];
            mem_full_out  <= wrap_nxt;
        end
    end

    // Trace store, written only from the FIFO
    always_ff @(posedge core_clk_in) begin
        if (ce_in && mem_we)
            mem_r[wr_ptr_r] <= f_out;
    end

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_r);

    sequence s_start_cyc;
        acc && start_h && !end_h && !win_r;
    endsequence
    sequence s_end_cyc;
        acc && end_h && win_r;
    endsequence
    logic qual_on;
    assign qual_on = mode != trace_qual_pkg::repeat_stop_mode
                     && mode != trace_qual_pkg::repeat_full_mode;

    repeat_stores_a: assert property (!qual_on && acc |-> store)
        else $error("repeat mode dropped a cycle");
    ext_between_a: assert property (
        qual == trace_qual_pkg::ext_between && qual_on
        ##0 s_start_cyc |-> store ##1 win_r)
        else $error("start cycle not stored");
    between_end_a: assert property (
        (qual == trace_qual_pkg::ext_between
         || qual == trace_qual_pkg::elim_between) && qual_on
        ##0 s_end_cyc |-> !store ##1 !win_r)
        else $error("end cycle stored or window open");
    elim_between_a: assert property (
        qual == trace_qual_pkg::elim_between && qual_on
        && acc && (start_h || win_r) |-> !store)
        else $error("eliminated cycle stored");
    ext_during_a: assert property (
        qual == trace_qual_pkg::ext_during && qual_on && acc
        |-> store == sel_h)
        else $error("during extraction mismatch");
    elim_during_a: assert property (
        qual == trace_qual_pkg::elim_during && qual_on && acc
        |-> store == !sel_h)
        else $error("during elimination mismatch");
    subroutine_a: assert property (
        qual == trace_qual_pkg::ext_subroutine && qual_on && acc
        && !in_rng |-> !store)
        else $error("out of range event stored");
    data_extract_a: assert property (
        qual == trace_qual_pkg::ext_data_access && qual_on && acc
        |-> store == bus_cycle_in.data_hit)
        else $error("data access extraction mismatch");
    aux_event_a: assert property (
        acc && aux_sel == trace_qual_pkg::aux_event_number
        && event_hit_in[0] |-> rec.aux == 8'h80)
        else $error("event number field wrong");
    config_hold_a: assert property (
        ce_in && run_r ##1 run_r
        |-> $stable(ctrl_r[trace_qual_pkg::CTRL_W-1:1]))
        else $error("qualification changed while running");
    read_intact_a: assert property (mem_rd |-> !mem_we)
        else $error("store written during record read");
    circular_wrap_a: assert property (
        ce_in && mem_we && wr_ptr_r == '1
        |=> wr_ptr_r == '0 && wrap_r)
        else $error("trace store did not wrap");
    no_qual_a: assert property (
        qual == trace_qual_pkg::qual_none && acc |-> store)
        else $error("unqualified cycle dropped");
endmodule : trace_capture_qualifier

`default_nettype wire

// file: tb/trace_bus_model.sv
// Model of the monitored processor bus and its event detectors.
// Assumes one bus-cycle clock shared with the qualifier.
`timescale 1ns/1ps
`default_nettype none

module trace_bus_model (
    // Clock and flow control
    input  wire logic                       clk_in,
    input  wire logic                       ready_in,
    // Bus cycle and event hits
    output logic                            valid_out,
    output trace_qual_pkg::bus_cycle_t      cyc_out,
    output logic [trace_qual_pkg::N_EV-1:0] hit_out,
    output logic [7:0]                      task_out,
    output logic                            trig_out
);
    // Quiet bus at time zero
    initial begin
        valid_out = 1'b0;
        cyc_out   = '0;
        hit_out   = '0;
        task_out  = 8'h00;
        trig_out  = 1'b0;
    end

    // Released cycle and task lines show the inverse and valid and hits drop to zero, so stale values never look valid
    task automatic idle();
        valid_out <= 1'b0;
        cyc_out   <= ~cyc_out;
        hit_out   <= '0;
        task_out  <= ~task_out;
    endtask : idle

    // Drive the trigger pin just after an edge
    task automatic trigger(input logic v);
        @(posedge clk_in);
        trig_out <= v;
    endtask : trigger

    // Cycle i: address 0x100+i, events 1 and 2 from the masks
    task automatic send(input int n, input int gap,
                        input logic [31:0] a, input logic [31:0] b,
                        input logic [31:0] dh);
        for (int i = 0; i < n; i++) begin
            valid_out <= 1'b1;
            cyc_out   <= '{addr: 24'h000100 + 24'(i),
                           data: 16'h5a00 | 16'(i),
                           data_hit: dh[i]};
            hit_out   <= (16'(a[i]) << 1) | (16'(b[i]) << 2);
            task_out  <= 8'h30 | 8'(i);
            // Hold the cycle until an edge sees ready high
            do @(posedge clk_in); while (!ready_in);
            if (gap != 0) begin
                idle();
                @(posedge clk_in);
            end
        end
        idle();
    endtask : send
endmodule : trace_bus_model
`default_nettype wire

// file: tb/trace_capture_qualifier_tb.sv
// Self-checking bench: register tasks, bus model and case table.
// Assumes a small store (MEM_AW 4) so wrapping is quick.
`timescale 1ns/1ps
`default_nettype none

module trace_capture_qualifier_tb;
    localparam int MAW = 4;
    logic                       clk, rst_b, ce, wr, rd;
    logic [7:0]                 addr;
    logic [31:0]                wdata, rdata, d;
    logic                       valid, ready, acq, full, trig;
    trace_qual_pkg::bus_cycle_t cyc;
    logic [15:0]                hit;
    logic [7:0]                 tsk;
    int                         miscompares, num_checks;

    trace_capture_qualifier #(.MEM_AW(MAW)) trace_capture_qualifier_i (
        .core_clk_in(clk), .rst_b_in(rst_b), .ce_in(ce),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .bus_valid_in(valid),
        .bus_cycle_in(cyc), .event_hit_in(hit),
        .os_task_identifier_in(tsk), .ext_trigger_in(trig),
        .bus_ready_out(ready), .acquiring_out(acq), .mem_full_out(full));

    trace_bus_model trace_bus_model_i (
        .clk_in(clk), .ready_in(ready), .valid_out(valid), .cyc_out(cyc),
        .hit_out(hit), .task_out(tsk), .trig_out(trig));

    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    // Start event 1, end event 2, selected event 1
    function automatic logic [31:0] ctrl(input int m, input int q,
                                         input int x);
        return 32'h00024201 | (32'(x) << 7) | (32'(q) << 4) | (32'(m) << 1);
    endfunction : ctrl

    // Poll the write pointer under a bound, then compare it
    task automatic run_case(input int m, input int q, input int x,
                            input int n, input int gap,
                            input logic [31:0] a, input logic [31:0] b,
                            input logic [31:0] dh, input logic [31:0] cnt,
                            input logic [31:0] first);
        int k;
        wr_reg(trace_qual_pkg::CTRL_OFS, ctrl(m, q, x));
        trace_bus_model_i.send(n, gap, a, b, dh);
        k = 0;
        do begin
            rd_reg(trace_qual_pkg::WR_PTR_OFS, d);
            k++;
        end while (d !== cnt && k < 40);
        chk(d, cnt, "record count");
        wr_reg(trace_qual_pkg::CTRL_OFS, 32'h0);
        wr_reg(trace_qual_pkg::MEM_ADR_OFS, 32'h0);
        rd_reg(trace_qual_pkg::MEM_LO_OFS, d);
        chk(d, first, "first record address");
        $display("case done mode %0d qual %0d", m, q);
    endtask : run_case

    // Watchdog, far beyond the expected run
    initial begin
        #500000;
        miscompares++;
        print_verdict();
    end

    // Main sequence
    initial begin
        miscompares = 0;
        num_checks  = 0;
        rst_b = 1'b0;
        ce    = 1'b1;
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = 8'h00;
        wdata = 32'h0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset values and an unmapped address
        rd_reg(trace_qual_pkg::CTRL_OFS, d);
        chk(d, 32'h0, "ctrl reset");
        rd_reg(8'hfc, d);
        chk(d, 32'h0, "unmapped read");
        chk(32'(acq), 32'h0, "idle after reset");
        wr_reg(trace_qual_pkg::RANGE_LO_OFS, 32'h103);
        wr_reg(trace_qual_pkg::RANGE_HI_OFS, 32'h105);
        // Range locked while running
        wr_reg(trace_qual_pkg::CTRL_OFS, ctrl(0, 0, 0));
        #1;
        chk(32'(acq), 32'h1, "running");
        wr_reg(trace_qual_pkg::RANGE_LO_OFS, 32'h0);
        rd_reg(trace_qual_pkg::RANGE_LO_OFS, d);
        chk(d, 32'h103, "range locked");
        wr_reg(trace_qual_pkg::CTRL_OFS, 32'h0);
        // Frozen clock enable ignores a write
        ce <= 1'b0;
        wr_reg(trace_qual_pkg::RANGE_LO_OFS, 32'h0);
        ce <= 1'b1;
        rd_reg(trace_qual_pkg::RANGE_LO_OFS, d);
        chk(d, 32'h103, "write under low enable");
        $display("case done lock");
        // No qualification stores all; event-number, task and trigger aux
        run_case(0, 0, 0, 2, 0, 32'h2, 0, 0, 2, 32'h100);
        wr_reg(trace_qual_pkg::MEM_ADR_OFS, 32'h1);
        rd_reg(trace_qual_pkg::MEM_HI_OFS, d);
        chk(d, 32'h00815a01, "event number aux");
        run_case(0, 0, 1, 2, 0, 0, 0, 0, 2, 32'h100);
        rd_reg(trace_qual_pkg::MEM_HI_OFS, d);
        chk(d, 32'h00305a00, "task aux");
        trace_bus_model_i.trigger(1'b1);
        run_case(0, 0, 2, 2, 0, 0, 0, 0, 2, 32'h100);
        rd_reg(trace_qual_pkg::MEM_HI_OFS, d);
        chk(d, 32'h00015a00, "trigger aux");
        // Qualification types, slow bus on the first
        run_case(0, 1, 0, 8, 1, 32'h04, 32'h20, 0, 3, 32'h102);
        run_case(0, 5, 0, 8, 0, 32'h04, 32'h20, 0, 4, 32'h100);
        run_case(0, 2, 0, 8, 0, 32'h0a, 0, 0, 2, 32'h101);
        run_case(0, 6, 0, 8, 0, 32'h0a, 0, 0, 6, 32'h100);
        run_case(0, 3, 0, 8, 0, 32'h8a, 0, 0, 1, 32'h103);
        run_case(0, 7, 0, 8, 0, 32'h8a, 0, 0, 7, 32'h100);
        run_case(0, 4, 0, 8, 0, 0, 0, 32'h30, 2, 32'h104);
        // Qualification applied in modes 1 and 2, ignored in the repeating modes 3 and 4
        for (int m = 1; m < 5; m++) begin
            run_case(m, 2, 0, 8, 0, 32'h0a, 0, 0, (m > 2) ? 8 : 2,
                     (m > 2) ? 32'h100 : 32'h101);
        end
        // Fill until full stops at the wrap, keeping the oldest
        run_case(1, 0, 0, 20, 0, 0, 0, 0, 0, 32'h100);
        // Circular store overwrites the oldest records
        run_case(0, 0, 0, 20, 0, 0, 0, 0, 4, 32'h110);
        chk(32'(full), 32'h1, "store wrapped");
        rd_reg(trace_qual_pkg::MEM_LO_OFS, d);
        chk(d, 32'h110, "record kept after reads");
        print_verdict();
    end
endmodule : trace_capture_qualifier_tb
`default_nettype wire
